/* src/epc_pkg.sv */
package epc_pkg;
  // Register byte addresses; the control register keeps its printed index
  localparam logic [11:0] CTRL_IDX = 12'h0f3;
  localparam logic [11:0] CTRL_ADDR = 12'h3cc; // Four times CTRL_IDX
  localparam logic [11:0] CFG_ADDR = 12'h3c0;
  localparam logic [11:0] STAT_ADDR = 12'h3e0;
  localparam int AXI_AW = 12;
  // Control and config register fields
  localparam int CTRL_PA = 0;
  localparam int CTRL_LA = 1;
  localparam int CTRL_WIPE = 2;
  localparam int CTRL_LINE = 3;
  localparam int CTRL_SINGLE = 4;
  localparam int CTRL_BULK = 7;
  localparam logic CTRL_BULK_RST = 1'h1;
  localparam int CFG_PL = 0;
  // Array window
  localparam logic [15:0] ARR_LO = 16'h0d00;
  localparam logic [15:0] ARR_HI = 16'h0fff;
  // Operation kinds, one-hot
  localparam logic [3:0] KIND_PROGRAM = 4'h1;
  localparam logic [3:0] KIND_SINGLE = 4'h2;
  localparam logic [3:0] KIND_ROW = 4'h4;
  localparam logic [3:0] KIND_BULK = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* src/epc_latch.sv */
`timescale 1ns/10ps
module epc_latch (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic word,
  output logic [15:0] lat_addr,
  output logic [15:0] lat_data,
  output logic lat_word
);
  // Captures address and data; a misaligned word keeps only its lower byte
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lat_addr <= 16'h0000;
      lat_data <= 16'h0000;
      lat_word <= 1'b0;
    end else if (load) begin
      lat_addr <= addr; // RULE_06
      lat_word <= word && !addr[0]; // RULE_19
      lat_data <= (word && !addr[0]) ? wdata : {8'h00, wdata[7:0]}; // RULE_19
    end
  end

  AST_MISALIGNED_BYTE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_19
    load && word && addr[0] |=> !lat_word && lat_data[15:8] == 8'h00)
    else $error("misaligned word latched as word");
endmodule

/* src/epc_ctrl.sv */
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
// Notes on behaviour
// RULE_01: Bulk guard set refuses whole-array and row erase; single-location erase allowed.
// RULE_02: Bulk guard writable only while pump apply and protect lock are clear.
// RULE_03: Pump apply set freezes bulk guard, erase selects, wipe mode and latch arm. The code lets latch arm change in a write that clears pump apply.
// RULE_04: Single erase wins; else line select picks 32-byte row, clear picks whole array.
// RULE_05: Wipe mode clear ignores erase selects and means programming.
// RULE_06: Single erase outside test mode touches only the latched address and width.
// RULE_07: Wipe mode clear configures program or read; set configures erasure.
// RULE_08: Latch arm set blocks array data on every array read.
// RULE_09: With latch arm set, an array write loads the programming latches.
// RULE_10: Pump apply sets only if latch arm was already set beforehand.
// RULE_11: Pump apply drives program/erase voltage; clear removes it.
// RULE_12: Pump apply set ignores array writes and freezes latched address and data.
// RULE_13: Software clears pump apply and latch arm before reading back data.
// RULE_14: Software configures, arms, writes, applies pump, waits, then clears both.
// RULE_15: Software may clear only pump apply and repeat from the array write.
// RULE_16: Erase selects, wipe mode and latch arm accept writes together or apart.
// RULE_17: Software should poll and mask array-resident vectors while armed.
// RULE_18: Protect lock blocks bulk guard changes; write-once in normal modes.
// RULE_19: Misaligned word operations latch and act on the lower byte only.
// RULE_20: Stop mode removes voltage, keeps pump apply; leaving stop restores it.
// RULE_21: No internal timer; voltage lasts exactly while pump apply stays set.
module epc_ctrl (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic arr_wr_en,
  input wire logic arr_rd_en,
  input wire logic [15:0] arr_addr,
  input wire logic [15:0] arr_wdata,
  input wire logic arr_word,
  input wire logic [15:0] mem_rdata,
  output logic [15:0] arr_rdata,
  output logic arr_rack,
  input wire logic stop_mode,
  input wire logic test_mode_select_n,
  output logic pe_voltage_on,
  output logic op_enable,
  output logic [3:0] op_kind,
  output logic erase_refused,
  output logic [15:0] lat_addr,
  output logic [15:0] lat_data,
  output logic lat_word
);
  logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
  logic [11:0] awaddr_ff;
  logic [7:0] wbyte_ff;
  logic wlane0_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic wr_fire, ctrl_we, cfg_we;
  logic pa_ff, la_ff, wipe_ff, line_ff, single_ff, bulk_ff, pl_ff, pl_used_ff;
  logic nxt_la, nxt_pa;
  logic tmn_s1_ff, tmn_s2_ff;
  logic loaded_ff, pe_on_ff, arr_hit, lat_load;
  logic [15:0] arr_rdata_ff;
  logic arr_rack_ff;

  // Write channels are held separately so address and data may come in either order
  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready = !w_hold_ff && !bvalid_ff;
  assign wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign ctrl_we = wr_fire && wlane0_ff && awaddr_ff == epc_pkg::CTRL_ADDR;
  assign cfg_we = wr_fire && wlane0_ff && awaddr_ff == epc_pkg::CFG_ADDR;

  // Write address and data capture
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wbyte_ff <= 8'h00;
      wlane0_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wbyte_ff <= s_axi_wdata[7:0]; // Registers are 8 bits wide, lane 0 only
        wlane0_ff <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_hold_ff <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR and change nothing
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= epc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (awaddr_ff == epc_pkg::CTRL_ADDR || awaddr_ff == epc_pkg::CFG_ADDR ||
                   awaddr_ff == epc_pkg::STAT_ADDR) ? epc_pkg::RESP_OKAY : epc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // Read channel, one cycle after the address is taken
  assign s_axi_arready = !rvalid_ff;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= epc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= epc_pkg::RESP_OKAY;
      case (s_axi_araddr)
        epc_pkg::CTRL_ADDR: rdata_ff <= {24'h00_0000, bulk_ff, 2'b00, single_ff, line_ff,
                                         wipe_ff, la_ff, pa_ff};
        epc_pkg::CFG_ADDR: rdata_ff <= {31'h0000_0000, pl_ff};
        epc_pkg::STAT_ADDR: rdata_ff <= {24'h00_0000, loaded_ff, pe_on_ff, erase_refused,
                                         !tmn_s2_ff, op_kind};
        default: begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= epc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Test-mode strap comes from a pin, so it is synchronised first
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tmn_s1_ff <= 1'b1;
      tmn_s2_ff <= 1'b1;
    end else begin
      tmn_s1_ff <= test_mode_select_n;
      tmn_s2_ff <= tmn_s1_ff;
    end
  end

  // While pump apply is set, latch arm changes only in a write that also clears pump apply
  always_comb begin
    nxt_la = la_ff;
    if (ctrl_we && !(pa_ff && wbyte_ff[epc_pkg::CTRL_PA])) begin
      nxt_la = wbyte_ff[epc_pkg::CTRL_LA]; // RULE_03 RULE_16
    end
    nxt_pa = pa_ff;
    if (ctrl_we) begin
      nxt_pa = wbyte_ff[epc_pkg::CTRL_PA] && la_ff && nxt_la; // RULE_10
    end
  end

  // Pump apply and latch arm; no duration counter, software times the pulse
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pa_ff <= 1'b0;
      la_ff <= 1'b0;
    end else begin
      pa_ff <= nxt_pa; // RULE_21
      la_ff <= nxt_la;
    end
  end

  // Mode and granularity selects, frozen while the pump is applied
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wipe_ff <= 1'b0;
      line_ff <= 1'b0;
      single_ff <= 1'b0;
    end else if (ctrl_we && !pa_ff) begin
      wipe_ff <= wbyte_ff[epc_pkg::CTRL_WIPE]; // RULE_03 RULE_16
      line_ff <= wbyte_ff[epc_pkg::CTRL_LINE];
      single_ff <= wbyte_ff[epc_pkg::CTRL_SINGLE];
    end
  end

  // Bulk guard resets set so a stray pump cannot wipe the array
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bulk_ff <= epc_pkg::CTRL_BULK_RST;
    end else if (ctrl_we && !pa_ff && !pl_ff) begin
      bulk_ff <= wbyte_ff[epc_pkg::CTRL_BULK]; // RULE_02 RULE_18
    end
  end

  // Protect lock: once per reset in normal mode, freely in test mode
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pl_ff <= 1'b0;
      pl_used_ff <= 1'b0;
    end else if (cfg_we && (!tmn_s2_ff || !pl_used_ff)) begin
      pl_ff <= wbyte_ff[epc_pkg::CFG_PL]; // RULE_18
      pl_used_ff <= tmn_s2_ff;
    end
  end

  // Array writes go to the latches only while armed and unpowered
  assign arr_hit = arr_addr >= epc_pkg::ARR_LO && arr_addr <= epc_pkg::ARR_HI;
  assign lat_load = arr_wr_en && arr_hit && la_ff && !pa_ff; // RULE_09 RULE_12

  epc_latch epc_latch_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(lat_load),
    .addr(arr_addr),
    .wdata(arr_wdata),
    .word(arr_word),
    .lat_addr(lat_addr),
    .lat_data(lat_data),
    .lat_word(lat_word)
  );

  // Loaded flag keeps a pump without latched data from acting on the array
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      loaded_ff <= 1'b0;
    end else if (lat_load) begin
      loaded_ff <= 1'b1;
    end else if (!nxt_la) begin
      loaded_ff <= 1'b0;
    end
  end

  // Voltage follows pump apply, dropped during stop and restored after
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pe_on_ff <= 1'b0;
    end else begin
      pe_on_ff <= pa_ff && !stop_mode; // RULE_11 RULE_20
    end
  end
  assign pe_voltage_on = pe_on_ff;

  // Operation decode: program unless wiping, then single, row or bulk
  always_comb begin
    if (!wipe_ff) begin
      op_kind = epc_pkg::KIND_PROGRAM; // RULE_05 RULE_07
    end else if (single_ff) begin
      op_kind = epc_pkg::KIND_SINGLE; // RULE_04 RULE_06
    end else if (line_ff) begin
      op_kind = epc_pkg::KIND_ROW; // RULE_04
    end else begin
      op_kind = epc_pkg::KIND_BULK;
    end
  end
  assign erase_refused = wipe_ff && !single_ff && bulk_ff; // RULE_01
  assign op_enable = pe_on_ff && loaded_ff && !erase_refused; // RULE_01

  // Array reads answer a cycle later; armed reads return zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      arr_rack_ff <= 1'b0;
      arr_rdata_ff <= 16'h0000;
    end else begin
      arr_rack_ff <= arr_rd_en && arr_hit;
      if (arr_rd_en && arr_hit) begin
        arr_rdata_ff <= la_ff ? 16'h0000 : mem_rdata; // RULE_08
      end
    end
  end
  assign arr_rack = arr_rack_ff;
  assign arr_rdata = arr_rdata_ff;

  AST_BULK_REFUSED: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_01
    bulk_ff && wipe_ff && !single_ff |-> !op_enable && erase_refused)
    else $error("bulk or row erase enabled under bulk guard");
  AST_GUARD_LOCKED: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_02
    pa_ff || pl_ff |=> $stable(bulk_ff))
    else $error("bulk guard changed while locked");
  AST_SELECTS_FROZEN: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_03
    pa_ff |=> $stable({wipe_ff, line_ff, single_ff}))
    else $error("selects changed under pump apply");
  AST_ARM_HELD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_03
    pa_ff ##1 pa_ff |-> $stable(la_ff))
    else $error("latch arm changed under pump apply");
  AST_ROW_DECODE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_04
    wipe_ff && !single_ff && line_ff |-> op_kind == epc_pkg::KIND_ROW)
    else $error("row erase decode wrong");
  AST_PROGRAM_DECODE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_05
    !wipe_ff |-> op_kind == epc_pkg::KIND_PROGRAM)
    else $error("program decode wrong");
  AST_READ_BLOCKED: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_08
    arr_rd_en && arr_hit && la_ff |=> arr_rack && arr_rdata == 16'h0000)
    else $error("array data returned while armed");
  AST_LATCH_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_09
    lat_load |=> lat_addr == $past(arr_addr) && loaded_ff)
    else $error("armed write not latched");
  AST_PUMP_NEEDS_ARM: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_10
    !pa_ff ##1 pa_ff |-> $past(la_ff) && la_ff)
    else $error("pump apply set without prior latch arm");
  AST_VOLTAGE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_11
    pa_ff && !stop_mode |=> pe_voltage_on)
    else $error("voltage missing under pump apply");
  AST_STOP_DROPS: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_20
    stop_mode || !pa_ff |=> !pe_voltage_on)
    else $error("voltage present in stop or without pump apply");
  AST_LATCH_FROZEN: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_12
    pa_ff |=> $stable(lat_addr) && $stable(lat_data))
    else $error("latches changed under pump apply");
endmodule

/* dv/tb_epc_ctrl.sv */
`timescale 1ns/10ps
module tb_epc_ctrl;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic wr_en = 1'b0, rd_en = 1'b0, word = 1'b0, stop = 1'b0;
  logic tmn = 1'b1;
  logic [3:0] strb = 4'hf;
  logic [31:0] wd = '0;
  logic [15:0] a_addr = '0, a_wd = '0, mem = '0;
  wire logic aw_r, w_r, b_v, ar_r, r_v, rack, pev, ope, refd, lword;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rd;
  wire logic [15:0] ardata, laddr, ldata;
  wire logic [3:0] kind;
  int miscompares = 0;
  int samples_checked = 0;

  // 250 MHz bench clock
  always #2 sys_clk = ~sys_clk;

  // Strap and byte strobe are driven so test mode and a dropped lane 0 get exercised
  epc_ctrl epc_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(wd), .s_axi_wstrb(strb),
    .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(bresp), .s_axi_bvalid(b_v),
    .s_axi_bready(b_r), .s_axi_araddr(araddr), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .arr_wr_en(wr_en), .arr_rd_en(rd_en), .arr_addr(a_addr), .arr_wdata(a_wd),
    .arr_word(word), .mem_rdata(mem), .arr_rdata(ardata), .arr_rack(rack),
    .stop_mode(stop), .test_mode_select_n(tmn), .pe_voltage_on(pev), .op_enable(ope),
    .op_kind(kind), .erase_refused(refd), .lat_addr(laddr), .lat_data(ldata),
    .lat_word(lword));

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_sig(input logic [15:0] got, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic timeout();
    miscompares++;
    $display("unexpected at %0t: handshake never came", $time);
    end_of_test();
  endtask

  // Handshakes are judged at the falling edge so the outcome never races the rising edge
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_hs, w_hs, b_hs;
    @(posedge sys_clk);
    awaddr <= a;
    wd <= {24'h00_0000, d};
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(negedge sys_clk);
      aw_hs = aw_v & aw_r;
      w_hs = w_v & w_r;
      b_hs = b_v & b_r;
      if (b_hs) chk_reg({30'h0, bresp}, {30'h0, er}, "write response");
      @(posedge sys_clk);
      if (aw_hs) aw_v <= 1'b0;
      if (w_hs) w_v <= 1'b0;
      if (b_hs) begin
        b_r <= 1'b0;
        return;
      end
    end
    timeout();
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp,
                        input logic [1:0] er);
    logic ar_hs, r_hs;
    @(posedge sys_clk);
    araddr <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(negedge sys_clk);
      ar_hs = ar_v & ar_r;
      r_hs = r_v & r_r;
      if (r_hs) begin
        chk_reg(rd & m, exp, "read data");
        chk_reg({30'h0, rresp}, {30'h0, er}, "read response");
      end
      @(posedge sys_clk);
      if (ar_hs) ar_v <= 1'b0;
      if (r_hs) begin
        r_r <= 1'b0;
        return;
      end
    end
    timeout();
  endtask

  // Array strobes are single-cycle pulses
  task automatic arr_wr(input logic [15:0] a, input logic [15:0] d, input logic w);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    a_addr <= a;
    a_wd <= d;
    word <= w;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  task automatic arr_rd(input logic [15:0] a, input logic [15:0] m, input logic [15:0] exp);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    a_addr <= a;
    mem <= m;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    @(negedge sys_clk);
    chk_sig({15'h0, rack}, 16'h0001, "read acknowledge");
    chk_sig(ardata, exp, "array read data");
  endtask

  // Voltage output lags the control bit by one cycle, so allow two
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic t_reset();
    axi_rd(epc_pkg::CTRL_ADDR, 32'hffff_ffff, 32'h0000_0080, epc_pkg::RESP_OKAY);
    axi_rd(epc_pkg::STAT_ADDR, 32'h0000_00ef, 32'h0000_0001, epc_pkg::RESP_OKAY);
    axi_rd(epc_pkg::CFG_ADDR, 32'hffff_ffff, 32'h0000_0000, epc_pkg::RESP_OKAY);
    axi_wr(12'h100, 8'h01, epc_pkg::RESP_SLVERR);
    axi_rd(12'h100, 32'hffff_ffff, 32'h0000_0000, epc_pkg::RESP_SLVERR);
    // Without lane 0 the write is answered but must leave the control byte alone
    strb <= 4'he;
    axi_wr(epc_pkg::CTRL_ADDR, 8'h02, epc_pkg::RESP_OKAY);
    axi_rd(epc_pkg::CTRL_ADDR, 32'hffff_ffff, 32'h0000_0080, epc_pkg::RESP_OKAY);
    strb <= 4'hf;
    $display("test reset and bus errors done");
  endtask

  task automatic t_program();
    axi_wr(epc_pkg::CTRL_ADDR, 8'h83, epc_pkg::RESP_OKAY);
    axi_rd(epc_pkg::CTRL_ADDR, 32'hffff_ffff, 32'h0000_0082, epc_pkg::RESP_OKAY);
    settle();
    chk_sig({15'h0, pev}, 16'h0000, "no voltage before pump");
    arr_wr(16'h0d10, 16'h5a3c, 1'b1);
    settle();
    chk_sig(laddr, 16'h0d10, "latched address");
    chk_sig(ldata, 16'h5a3c, "latched data");
    chk_sig({15'h0, lword}, 16'h0001, "latched width");
    arr_rd(16'h0d10, 16'h1234, 16'h0000);
    axi_wr(epc_pkg::CTRL_ADDR, 8'h83, epc_pkg::RESP_OKAY);
    settle();
    chk_sig({14'h0, pev, ope}, 16'h0003, "voltage applied");
    axi_rd(epc_pkg::STAT_ADDR, 32'h0000_00ef, 32'h0000_00c1, epc_pkg::RESP_OKAY);
    arr_wr(16'h0d20, 16'h1111, 1'b1);
    settle();
    chk_sig(laddr, 16'h0d10, "frozen address");
    chk_sig(ldata, 16'h5a3c, "frozen data");
    axi_wr(epc_pkg::CTRL_ADDR, 8'h1f, epc_pkg::RESP_OKAY);
    axi_rd(epc_pkg::CTRL_ADDR, 32'hffff_ffff, 32'h0000_0083, epc_pkg::RESP_OKAY);
    stop <= 1'b1;
    settle();
    chk_sig({15'h0, pev}, 16'h0000, "voltage off in stop");
    axi_rd(epc_pkg::CTRL_ADDR, 32'hffff_ffff, 32'h0000_0083, epc_pkg::RESP_OKAY);
    stop <= 1'b0;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    chk_sig({15'h0, pev}, 16'h0001, "voltage back and untimed");
    axi_wr(epc_pkg::CTRL_ADDR, 8'h82, epc_pkg::RESP_OKAY);
    settle();
    chk_sig({15'h0, pev}, 16'h0000, "voltage removed");
    arr_wr(16'h0d21, 16'h7788, 1'b1);
    settle();
    chk_sig({7'h0, lword, ldata[7:0]}, 16'h0088, "misaligned low byte");
    axi_wr(epc_pkg::CTRL_ADDR, 8'h00, epc_pkg::RESP_OKAY);
    arr_rd(16'h0d10, 16'h1234, 16'h1234);
    $display("test program sequence done");
  endtask

  task automatic t_erase_kinds();
    // Control value written, then expected status: refused in bit 5, kind in bits 3:0
    logic [7:0] wv [9] = '{8'h00, 8'h18, 8'h04, 8'h0c, 8'h14, 8'h1c, 8'h84, 8'h8c, 8'h94};
    logic [7:0] ev [9] = '{8'h01, 8'h01, 8'h08, 8'h04, 8'h02, 8'h02, 8'h28, 8'h24, 8'h02};
    for (int i = 0; i < 9; i++) begin
      axi_wr(epc_pkg::CTRL_ADDR, wv[i], epc_pkg::RESP_OKAY);
      axi_rd(epc_pkg::CTRL_ADDR, 32'hffff_ffff, {24'h00_0000, wv[i]}, epc_pkg::RESP_OKAY);
      axi_rd(epc_pkg::STAT_ADDR, 32'h0000_00ef, {24'h00_0000, ev[i]}, epc_pkg::RESP_OKAY);
      chk_sig({11'h0, refd, kind}, {11'h0, ev[i][5], ev[i][3:0]}, "erase decode");
      chk_sig({12'h0, kind}, {12'h0, ev[i][3:0]}, "program when not wiping");
    end
    $display("test erase kinds done");
  endtask

  task automatic t_lock();
    axi_wr(epc_pkg::CTRL_ADDR, 8'h00, epc_pkg::RESP_OKAY);
    axi_wr(epc_pkg::CFG_ADDR, 8'h01, epc_pkg::RESP_OKAY);
    axi_rd(epc_pkg::CFG_ADDR, 32'hffff_ffff, 32'h0000_0001, epc_pkg::RESP_OKAY);
    axi_wr(epc_pkg::CTRL_ADDR, 8'h80, epc_pkg::RESP_OKAY);
    axi_rd(epc_pkg::CTRL_ADDR, 32'hffff_ffff, 32'h0000_0000, epc_pkg::RESP_OKAY);
    axi_wr(epc_pkg::CFG_ADDR, 8'h00, epc_pkg::RESP_OKAY);
    axi_rd(epc_pkg::CFG_ADDR, 32'hffff_ffff, 32'h0000_0001, epc_pkg::RESP_OKAY);
    // Test mode strap: the lock may be cleared again, which frees the bulk guard
    tmn <= 1'b0;
    settle();
    axi_rd(epc_pkg::STAT_ADDR, 32'h0000_0010, 32'h0000_0010, epc_pkg::RESP_OKAY);
    axi_wr(epc_pkg::CFG_ADDR, 8'h00, epc_pkg::RESP_OKAY);
    axi_rd(epc_pkg::CFG_ADDR, 32'hffff_ffff, 32'h0000_0000, epc_pkg::RESP_OKAY);
    axi_wr(epc_pkg::CTRL_ADDR, 8'h80, epc_pkg::RESP_OKAY);
    axi_rd(epc_pkg::CTRL_ADDR, 32'hffff_ffff, 32'h0000_0080, epc_pkg::RESP_OKAY);
    tmn <= 1'b1;
    $display("test protect lock done");
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_program();
    t_erase_kinds();
    t_lock();
    end_of_test();
  end
endmodule
